// [cpt_cfg.svh]
// Register offsets, field positions, reset values and timing figures of the calendar/timer.
`ifndef CPT_CFG_SVH
`define CPT_CFG_SVH
`define CPT_A_WEEK      7'h13
`define CPT_A_DATE      7'h14
`define CPT_A_MONTH     7'h15
`define CPT_A_YEAR      7'h16
`define CPT_A_TPLO      7'h1B
`define CPT_A_TPHI      7'h1C
`define CPT_A_EXT       7'h1D
`define CPT_A_FLAG      7'h1E
`define CPT_A_CTRL      7'h1F
`define CPT_A_IRQC      7'h32
`define CPT_EXT_TE      4
`define CPT_FLAG_TF     4
`define CPT_CTRL_STOP   6
`define CPT_CTRL_TIE    4
`define CPT_CTRL_COUNTDOWN_PAUSE   2
`define CPT_CTRL_BACKUP_SIDE_COUNT_SELECT  1
`define CPT_CTRL_SUPPLY_MODE_COUNT_FILTER   0
`define CPT_IRQC_TIMER_IRQ_PIN_SELECT  2
`define CPT_IRQC_MASK   8'h17
`define CPT_RST_WEEK    8'h01
`define CPT_RST_DATE    8'h01
`define CPT_RST_MONTH   8'h01
`define CPT_RST_YEAR    8'h00
`define CPT_RST_REG     8'h00
`define CPT_RD_MISS     8'hFF
`define CPT_MCLK_NS     50
`define CPT_TICK4K_NS   244141
`define CPT_REL_FAST_NS 122000
`define CPT_REL_SLOW_NS 7813000
`endif

// [cpt_pkg.sv]
// Types shared by the calendar and periodic timer block.
package cpt_pkg;
  typedef enum logic [1:0] {
    CPT_ST_CMD  = 2'b00,
    CPT_ST_WAIT = 2'b01,
    CPT_ST_RD   = 2'b10,
    CPT_ST_WR   = 2'b11
  } cpt_spi_e;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } cpt_wr_s;
  typedef enum logic [2:0] {
    CPT_SRC_4K   = 3'b000,
    CPT_SRC_64   = 3'b001,
    CPT_SRC_1    = 3'b010,
    CPT_SRC_MIN  = 3'b011,
    CPT_SRC_HOUR = 3'b100
  } cpt_src_e;
endpackage

// [cpt_top.sv]
// Calendar counters and periodic countdown timer with an SPI register port.
// What this block does
// - Weekday is a one-hot value in bits 0 to 6, bit 7 reads zero.
// - Each hour carry rotates the weekday left, 40h wraps to 01h.
// - The weekday feeds no carry into date, month or year.
// - Date counts BCD from 1 to 28..31 depending on month and leap year.
// - Month counts BCD 1 to 12, advancing on date carry.
// - Year counts BCD 00 to 99 and wraps, advancing on month carry.
// - Leap year is found from the year and sets February length.
// - Sixteen-bit preset, low byte in first register, high byte in second.
// - Counter reads give preset with enable low, live count with enable high.
// - Source select picks 4096 Hz, 64 Hz, 1 Hz, per minute or per hour.
// - Interrupt releases itself after 122 us on 4096 Hz, else 7.813 ms.
// - First countdown period may be up to one source tick short.
// - Prescaler position below the source tick is never readable.
// - Clearing timer enable stops counting but keeps an active interrupt.
// - Enable rising always restarts the countdown from the preset.
// - Expiry sets the event flag; only writing 0 clears it.
// - Timer can pause and resume without losing its count.
// - Stopped timer with interrupt off leaves counter registers as storage.
// - Expiry with interrupt enable drives the selected line low, else nothing.
// - Pin select 0 routes to line b, 1 routes to line a.
// - Countdown starts when the enabling write takes effect.
`timescale 1ns/10ps
`include "cpt_cfg.svh"
module cpt_top #(
  parameter int TICK_CYC     = `CPT_TICK4K_NS / `CPT_MCLK_NS,
  parameter int REL_FAST_CYC = `CPT_REL_FAST_NS / `CPT_MCLK_NS,
  parameter int REL_SLOW_CYC = `CPT_REL_SLOW_NS / `CPT_MCLK_NS
) (
  input  wire logic MCLK_IN,
  input  wire logic RST_B_IN,
  input  wire logic HOUR_CARRY_IN,
  input  wire logic SPI_SCLK_IN,
  input  wire logic SPI_CS_B_IN,
  input  wire logic SPI_MOSI_IN,
  output logic      SPI_MISO_OUT,
  output logic      IRQ_A_OUT,
  output logic      IRQ_A_OE_OUT,
  output logic      IRQ_B_OUT,
  output logic      IRQ_B_OE_OUT
);
  import cpt_pkg::*;

  localparam int PW = $clog2(TICK_CYC + 1);
  localparam int RW = $clog2(REL_SLOW_CYC + 1);

  if (TICK_CYC < 2 || REL_FAST_CYC < 8 || REL_SLOW_CYC < REL_FAST_CYC) begin : g_chk
    $error("cpt_top: timing parameters out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link side: runs on the serial clock, frames bounded by chip select.
  cpt_spi_e   spi_st;
  logic [2:0] bit_cnt;
  logic [6:0] in_sh;
  logic [7:0] out_sh;
  cpt_wr_s    wr_hold;
  logic [6:0] rd_addr;
  logic       wr_tog;
  logic       rd_req_tog;
  logic [2:0] ack_s;
  wire        spi_rst_b = RST_B_IN & ~SPI_CS_B_IN;
  wire  [7:0] in_byte   = {in_sh, SPI_MOSI_IN};
  wire        byte_end  = (bit_cnt == 3'd7);
  logic       rd_ack_tog;
  logic [7:0] rd_data;
  wire        rd_ok     = (ack_s[1] == ack_s[2]) && (ack_s[2] == rd_req_tog);

  // Chip select high ends the frame and returns the framer to the command byte.
  always_ff @(posedge SPI_SCLK_IN or negedge spi_rst_b) begin
    if (!spi_rst_b) begin
      spi_st  <= CPT_ST_CMD;
      bit_cnt <= 3'd0;
      in_sh   <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'd1;
      in_sh   <= in_byte[6:0];
      if (byte_end) begin
        case (spi_st)
          CPT_ST_CMD:  spi_st <= in_byte[7] ? CPT_ST_WAIT : CPT_ST_WR;
          CPT_ST_WAIT: spi_st <= CPT_ST_RD;
          CPT_ST_RD:   spi_st <= CPT_ST_CMD;
          CPT_ST_WR:   spi_st <= CPT_ST_CMD;
          default:     spi_st <= CPT_ST_CMD;
        endcase
      end
    end
  end

  // Toggles and held words must survive the end of a frame, so only reset clears them.
  always_ff @(posedge SPI_SCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_hold    <= '0;
      rd_addr    <= 7'h00;
      wr_tog     <= 1'b0;
      rd_req_tog <= 1'b0;
      out_sh     <= 8'h00;
      ack_s      <= 3'b000;
    end else begin
      ack_s <= {ack_s[1:0], rd_ack_tog};
      if (!SPI_CS_B_IN && byte_end && spi_st == CPT_ST_CMD) begin
        if (in_byte[7]) begin
          rd_addr    <= in_byte[6:0];
          rd_req_tog <= ~rd_req_tog;
        end else begin
          wr_hold.addr <= in_byte[6:0];
        end
      end
      if (!SPI_CS_B_IN && byte_end && spi_st == CPT_ST_WR) begin
        wr_hold.data <= in_byte;
        wr_tog       <= ~wr_tog;
      end
      if (!SPI_CS_B_IN && byte_end && spi_st == CPT_ST_WAIT) begin
        out_sh <= rd_ok ? rd_data : `CPT_RD_MISS;
      end else begin
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  // Data changes on the falling edge so the host samples it on the next rising edge.
  always_ff @(negedge SPI_SCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SPI_MISO_OUT <= 1'b0;
    end else begin
      SPI_MISO_OUT <= out_sh[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing into the main clock: three flops, a change counts when stages two and three agree.
  wire  [1:0] xev;
  wire  [1:0] tog_in = {rd_req_tog, wr_tog};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [2:0] sync;
    logic       stab;
    logic       ev;
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        sync <= 3'b000;
        stab <= 1'b0;
        ev   <= 1'b0;
      end else begin
        sync <= {sync[1:0], tog_in[i]};
        ev   <= (sync[1] == sync[2]) && (sync[2] != stab);
        if (sync[1] == sync[2]) begin
          stab <= sync[2];
        end
      end
    end
    assign xev[i] = ev;
  end

  wire wr_ev = xev[0];
  wire rd_ev = xev[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode.
  logic [7:0]  week, date, month, year;
  logic [15:0] preset, cnt;
  logic [7:0]  ext, ctrl, irqc;
  logic        tf, irq_act;
  logic [RW-1:0] rel_cnt;

  wire w_week  = wr_ev && (wr_hold.addr == `CPT_A_WEEK);
  wire w_date  = wr_ev && (wr_hold.addr == `CPT_A_DATE);
  wire w_month = wr_ev && (wr_hold.addr == `CPT_A_MONTH);
  wire w_year  = wr_ev && (wr_hold.addr == `CPT_A_YEAR);
  wire w_tplo  = wr_ev && (wr_hold.addr == `CPT_A_TPLO);
  wire w_tphi  = wr_ev && (wr_hold.addr == `CPT_A_TPHI);
  wire w_ext   = wr_ev && (wr_hold.addr == `CPT_A_EXT);
  wire w_flag  = wr_ev && (wr_hold.addr == `CPT_A_FLAG);
  wire w_ctrl  = wr_ev && (wr_hold.addr == `CPT_A_CTRL);
  wire w_irqc  = wr_ev && (wr_hold.addr == `CPT_A_IRQC);

  wire       te    = ext[`CPT_EXT_TE];
  wire       periodic_irq_enable   = ctrl[`CPT_CTRL_TIE];
  wire       timer_irq_pin_select = irqc[`CPT_IRQC_TIMER_IRQ_PIN_SELECT];
  wire [2:0] tsel  = ext[2:0];
  wire [15:0] cnt_view = te ? cnt : preset;

  logic [7:0] rd_mux;
  always_comb begin
    if (rd_addr == `CPT_A_WEEK) begin
      rd_mux = {1'b0, week[6:0]};
    end else if (rd_addr == `CPT_A_DATE) begin
      rd_mux = date;
    end else if (rd_addr == `CPT_A_MONTH) begin
      rd_mux = month;
    end else if (rd_addr == `CPT_A_YEAR) begin
      rd_mux = year;
    end else if (rd_addr == `CPT_A_TPLO) begin
      rd_mux = cnt_view[7:0];
    end else if (rd_addr == `CPT_A_TPHI) begin
      rd_mux = cnt_view[15:8];
    end else if (rd_addr == `CPT_A_EXT) begin
      rd_mux = ext;
    end else if (rd_addr == `CPT_A_FLAG) begin
      rd_mux = {3'b000, tf, 4'h0};
    end else if (rd_addr == `CPT_A_CTRL) begin
      rd_mux = ctrl;
    end else if (rd_addr == `CPT_A_IRQC) begin
      rd_mux = irqc;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // The read word is held until the next request, which keeps it stable for the link side.
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_data    <= 8'h00;
      rd_ack_tog <= 1'b0;
    end else if (rd_ev) begin
      rd_data    <= rd_mux;
      rd_ack_tog <= ~rd_ack_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calendar chain.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                      : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
  wire long_m  = (month == 8'h01 || month == 8'h03 || month == 8'h05 || month == 8'h07 ||
                  month == 8'h08 || month == 8'h10 || month == 8'h12);
  wire [7:0] last_day = (month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                        (long_m ? 8'h31 : 8'h30);
  wire date_co  = HOUR_CARRY_IN && (date == last_day);
  wire month_co = date_co && (month == 8'h12);

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      week <= `CPT_RST_WEEK;
    end else if (w_week) begin
      week <= {1'b0, wr_hold.data[6:0]};
    end else if (HOUR_CARRY_IN) begin
      week <= {1'b0, week[5:0], week[6]};
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      date  <= `CPT_RST_DATE;
      month <= `CPT_RST_MONTH;
      year  <= `CPT_RST_YEAR;
    end else begin
      if (w_date) begin
        date <= wr_hold.data;
      end else if (HOUR_CARRY_IN) begin
        date <= date_co ? 8'h01 : bcd_inc(date);
      end
      if (w_month) begin
        month <= wr_hold.data;
      end else if (date_co) begin
        month <= (month == 8'h12) ? 8'h01 : bcd_inc(month);
      end
      if (w_year) begin
        year <= wr_hold.data;
      end else if (month_co) begin
        year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running prescaler; not reset on start, so the first period may be short.
  logic [PW-1:0] p4k;
  logic [5:0]    p64, p1, pmin, phr;
  wire t4k  = (p4k == PW'(TICK_CYC - 1));
  wire t64  = t4k && (p64 == 6'd63);
  wire t1   = t64 && (p1 == 6'd63);
  wire tmin = t1 && (pmin == 6'd59);
  wire thr  = tmin && (phr == 6'd59);

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      p4k  <= '0;
      p64  <= 6'd0;
      p1   <= 6'd0;
      pmin <= 6'd0;
      phr  <= 6'd0;
    end else begin
      p4k <= t4k ? '0 : p4k + PW'(1);
      if (t4k) p64 <= p64 + 6'd1;
      if (t64) p1 <= p1 + 6'd1;
      if (t1) pmin <= tmin ? 6'd0 : pmin + 6'd1;
      if (tmin) phr <= thr ? 6'd0 : phr + 6'd1;
    end
  end

  logic src_tick;
  always_comb begin
    case (tsel)
      CPT_SRC_4K:   src_tick = t4k;
      CPT_SRC_64:   src_tick = t64;
      CPT_SRC_1:    src_tick = t1;
      CPT_SRC_MIN:  src_tick = tmin;
      CPT_SRC_HOUR: src_tick = thr;
      default:      src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Countdown, flag and interrupt.
  logic te_d;
  wire  te_rise = te && !te_d;
  // Supply mode is not sensed here; normal mode is assumed for the count filter.
  wire  filt_ok = !ctrl[`CPT_CTRL_SUPPLY_MODE_COUNT_FILTER] || !ctrl[`CPT_CTRL_BACKUP_SIDE_COUNT_SELECT];
  wire  paused  = ctrl[`CPT_CTRL_COUNTDOWN_PAUSE] && !ctrl[`CPT_CTRL_SUPPLY_MODE_COUNT_FILTER];
  wire  halted  = ctrl[`CPT_CTRL_STOP] && (tsel != CPT_SRC_4K);
  wire  run     = te && !te_rise && filt_ok && !paused && !halted;
  wire  expire  = run && src_tick && (cnt == 16'h0001);
  wire  fast    = (tsel == CPT_SRC_4K);
  wire [RW-1:0] rel_load = fast ? RW'(REL_FAST_CYC) : RW'(REL_SLOW_CYC);

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      preset <= 16'h0000;
      ext    <= `CPT_RST_REG;
      ctrl   <= `CPT_RST_REG;
      irqc   <= `CPT_RST_REG;
      te_d   <= 1'b0;
    end else begin
      te_d <= te;
      if (w_tplo) preset[7:0] <= wr_hold.data;
      if (w_tphi) preset[15:8] <= wr_hold.data;
      if (w_ext) ext <= wr_hold.data;
      if (w_ctrl) ctrl <= wr_hold.data;
      if (w_irqc) irqc <= wr_hold.data & `CPT_IRQC_MASK;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cnt <= 16'h0000;
    end else if (te_rise || expire) begin
      cnt <= preset;
    end else if (run && src_tick && cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end

  // A new expiry wins over a host clear arriving in the same cycle.
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tf <= 1'b0;
    end else if (expire) begin
      tf <= 1'b1;
    end else if (w_flag && !wr_hold.data[`CPT_FLAG_TF]) begin
      tf <= 1'b0;
    end
  end

  // Neither clearing the enable nor clearing the flag releases the line; only the
  // release timer or an interrupt enable of zero does.
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_act <= 1'b0;
      rel_cnt <= '0;
    end else if (!periodic_irq_enable) begin
      irq_act <= 1'b0;
      rel_cnt <= '0;
    end else if (expire) begin
      irq_act <= 1'b1;
      rel_cnt <= rel_load;
    end else if (irq_act) begin
      rel_cnt <= rel_cnt - RW'(1);
      irq_act <= (rel_cnt != RW'(1));
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IRQ_A_OUT    <= 1'b0;
      IRQ_A_OE_OUT <= 1'b0;
      IRQ_B_OUT    <= 1'b0;
      IRQ_B_OE_OUT <= 1'b0;
    end else begin
      IRQ_A_OE_OUT <= irq_act && timer_irq_pin_select;
      IRQ_B_OE_OUT <= irq_act && !timer_irq_pin_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_hr_nowr;
    HOUR_CARRY_IN && !w_week && !w_date && !w_month && !w_year;
  endsequence

  property p_wday_wrap;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) s_hr_nowr and week == 8'h40 |=> week == 8'h01;
  endproperty
  a_wday_wrap: assert property (p_wday_wrap) else $error("weekday did not wrap");

  property p_wday_hot;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) s_hr_nowr and $onehot(week) |=> $onehot(week) && !week[7];
  endproperty
  a_wday_hot: assert property (p_wday_hot) else $error("weekday lost one-hot");

  property p_feb_norm;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
      s_hr_nowr and month == 8'h02 && date == 8'h28 && year == 8'h01 |=> date == 8'h01 && month == 8'h03;
  endproperty
  a_feb_norm: assert property (p_feb_norm) else $error("february end wrong");

  property p_feb_leap;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
      s_hr_nowr and month == 8'h02 && date == 8'h28 && year == 8'h00 |=> date == 8'h29;
  endproperty
  a_feb_leap: assert property (p_feb_leap) else $error("leap day missed");

  property p_year_wrap;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
      s_hr_nowr and month == 8'h12 && date == 8'h31 && year == 8'h99 |=>
      month == 8'h01 && year == 8'h00 && date == 8'h01;
  endproperty
  a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

  property p_reload;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) expire |=> cnt == $past(preset) && tf;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload or flag on expiry");

  property p_start;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) te_rise |=> cnt == $past(preset);
  endproperty
  a_start: assert property (p_start) else $error("start not from preset");

  sequence s_irq_hold;
    irq_act [*8];
  endsequence
  property p_release;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) $rose(irq_act) && periodic_irq_enable && !w_ctrl |-> s_irq_hold;
  endproperty
  a_release: assert property (p_release) else $error("interrupt released too early");

  property p_no_tie;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) !periodic_irq_enable |=> !irq_act ##1 !IRQ_A_OE_OUT && !IRQ_B_OE_OUT;
  endproperty
  a_no_tie: assert property (p_no_tie) else $error("interrupt without enable");

  property p_route;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) irq_act && !timer_irq_pin_select |=> IRQ_B_OE_OUT && !IRQ_A_OE_OUT;
  endproperty
  a_route: assert property (p_route) else $error("interrupt on wrong line");

  property p_te_off;
    @(posedge MCLK_IN) disable iff (!RST_B_IN) irq_act && periodic_irq_enable && rel_cnt > RW'(1) && !w_ctrl |=> irq_act;
  endproperty
  a_te_off: assert property (p_te_off) else $error("interrupt dropped early");

  property p_rd_view;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
      rd_ev && rd_addr == `CPT_A_TPLO |=> rd_data == ($past(te) ? $past(cnt[7:0]) : $past(preset[7:0]));
  endproperty
  a_rd_view: assert property (p_rd_view) else $error("counter read view wrong");
endmodule // cpt_top

// [cpt_host.sv]
// Serial host model that reaches the calendar/timer registers in SPI mode 0.
`timescale 1ns/10ps
module cpt_host (
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  localparam int HALF = 32;
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
  end
  ////////////////////////////////////////
  // The clock rests low between frames, and data is flipped on release so that
  // a stale bit never looks valid to the device.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    #7;
    cs_b_out = 1'b0;
    for (int i = 0; i < (cmd[7] ? 24 : 16); i++) begin
      mosi_out = (i < 16) ? sh[15 - i] : ~mosi_out;
      #HALF;
      sclk_out = 1'b1;
      if (i >= 16) rd = {rd[6:0], miso_in};
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    cs_b_out = 1'b1;
    mosi_out = ~mosi_out;
    // The gap keeps two writes far enough apart for the clock-domain crossing.
    #600;
  endtask
endmodule // cpt_host

// [cpt_top_bench.sv]
// Self-checking bench for the calendar counters and the periodic timer.
`timescale 1ns/10ps
`include "cpt_cfg.svh"
module cpt_top_bench;
  import cpt_pkg::*;
  localparam int TICK = 8;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       hour_carry = 1'b0;
  logic       sclk, cs_b, mosi, miso, pin_sel;
  logic       irq_a, irq_a_oe, irq_b, irq_b_oe;
  logic [7:0] rd;
  logic [6:0] ra[11] = '{`CPT_A_WEEK, `CPT_A_DATE, `CPT_A_MONTH, `CPT_A_YEAR, `CPT_A_TPLO,
                         `CPT_A_TPHI, `CPT_A_EXT, `CPT_A_FLAG, `CPT_A_CTRL, `CPT_A_IRQC, 7'h40};
  logic [7:0] rv[11] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int         cd[4] = '{28, 28, 29, 31};
  int         cm[4] = '{2, 2, 2, 12};
  int         cy[4] = '{0, 1, 4, 99};
  logic [7:0] pz[3] = '{8'h04, 8'h40, 8'h03};
  int         hits = 0;
  int         error_cnt = 0;
  int         num_checks = 0;
  wire        sel_oe = pin_sel ? irq_a_oe : irq_b_oe;
  wire        other_oe = pin_sel ? irq_b_oe : irq_a_oe;

  cpt_top #(.TICK_CYC(TICK), .REL_FAST_CYC(8), .REL_SLOW_CYC(16)) i_cpt_top (
    .MCLK_IN(mclk), .RST_B_IN(rst_b), .HOUR_CARRY_IN(hour_carry), .SPI_SCLK_IN(sclk),
    .SPI_CS_B_IN(cs_b), .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .IRQ_A_OUT(irq_a),
    .IRQ_A_OE_OUT(irq_a_oe), .IRQ_B_OUT(irq_b), .IRQ_B_OE_OUT(irq_b_oe));
  cpt_host i_cpt_host (.sclk_out(sclk), .cs_b_out(cs_b), .mosi_out(mosi), .miso_in(miso));

  always #25 mclk = ~mclk;
  always @(negedge mclk) hits += int'(irq_a_oe === 1'b1 || irq_b_oe === 1'b1);
  ////////////////////////////////////////
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  function automatic int days(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_cpt_host.xfer({1'b0, a}, d, x);
  endtask
  task automatic rg(input logic [6:0] a, output logic [7:0] d);
    i_cpt_host.xfer({1'b1, a}, 8'h00, d);
  endtask
  // The live count is not frozen, so two matching reads are needed.
  task automatic rdcnt(output logic [15:0] v);
    logic [15:0] a;
    logic [7:0]  lo, hi;
    a = 16'hxxxx;
    for (int i = 0; i < 4; i++) begin
      rg(`CPT_A_TPLO, lo);
      rg(`CPT_A_TPHI, hi);
      v = {hi, lo};
      if (v === a) break;
      a = v;
    end
  endtask
  task automatic carry();
    @(negedge mclk) hour_carry = 1'b1;
    @(negedge mclk) hour_carry = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic cal(input int d, input int m, input int y, input int k);
    int nd, nm, ny;
    nd = (d == days(m, y)) ? 1 : d + 1;
    nm = (d == days(m, y)) ? m % 12 + 1 : m;
    ny = (d == days(m, y) && m == 12) ? (y + 1) % 100 : y;
    wr(`CPT_A_YEAR, bcd(y));
    wr(`CPT_A_MONTH, bcd(m));
    wr(`CPT_A_DATE, bcd(d));
    wr(`CPT_A_WEEK, 8'(1 << k));
    carry();
    rg(`CPT_A_DATE, rd);
    chk("date", bcd(nd), rd);
    rg(`CPT_A_MONTH, rd);
    chk("month", bcd(nm), rd);
    rg(`CPT_A_YEAR, rd);
    chk("year", bcd(ny), rd);
    rg(`CPT_A_WEEK, rd);
    chk("weekday", (k == 6) ? 16'h0001 : 16'(2 << k), rd);
  endtask
  // The first event after start may come early, so only later pulses are timed.
  task automatic tmr(input logic [2:0] src, input logic [15:0] pre, input logic pin,
                     input int per, input int rel);
    int w, p;
    pin_sel = pin;
    wr(`CPT_A_EXT, {5'h00, src});
    wr(`CPT_A_TPLO, pre[7:0]);
    wr(`CPT_A_TPHI, pre[15:8]);
    wr(`CPT_A_CTRL, 8'h10);
    wr(`CPT_A_IRQC, {5'h00, pin, 2'b00});
    wr(`CPT_A_EXT, {5'h02, src});
    for (w = 0; w < 2 * per + 99 && sel_oe !== 1'b1; w++) @(negedge mclk);
    for (w = 0; w < 2 * per && sel_oe === 1'b1; w++) @(negedge mclk);
    for (w = 0; w < 2 * per && sel_oe !== 1'b1; w++) @(negedge mclk);
    chk("other line", 16'h0000, 16'(other_oe));
    for (w = 0; w < 2 * per && sel_oe === 1'b1; w++) @(negedge mclk);
    for (p = w; p < 2 * per && sel_oe !== 1'b1; p++) @(negedge mclk);
    chk("release time", 16'(rel), 16'(w));
    chk("event period", 16'(per), 16'(p));
    wr(`CPT_A_EXT, {5'h00, src});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // The whole sequence needs about 1.2 ms; three milliseconds leave margin.
  initial begin
    #3_000_000;
    error_cnt++;
    summarize();
  end
  initial begin
    int k, m, y, d;
    logic [15:0] v1, v2;
    void'($urandom(32'he53b_da81));
    pin_sel = 1'b1;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    wr(7'h40, 8'h5a);
    foreach (ra[i]) begin
      rg(ra[i], rd);
      chk("reset or unmapped", rv[i], rd);
    end
    for (int i = 0; i < 4; i++) begin
      k = $urandom;
      wr(`CPT_A_TPLO, k[7:0]);
      wr(`CPT_A_TPHI, k[15:8]);
      rdcnt(v1);
      chk("stored preset", k[15:0], v1);
    end
    for (int i = 0; i < 12; i++) begin
      k = (i == 0) ? 6 : $urandom % 7;
      m = (i < 4) ? cm[i] : 1 + $urandom % 12;
      y = (i < 4) ? cy[i] : $urandom % 100;
      d = (i < 4) ? cd[i] : (i % 2) ? days(m, y) : 1 + $urandom % days(m, y);
      cal(d, m, y, k);
    end
    tmr(CPT_SRC_4K, 16'h0003, 1'b1, 3 * TICK, 8);
    tmr(CPT_SRC_64, 16'h0002, 1'b0, 128 * TICK, 16);
    rg(`CPT_A_FLAG, rd);
    chk("event flag set", 16'h0010, rd);
    wr(`CPT_A_FLAG, 8'h00);
    wr(`CPT_A_FLAG, 8'h10);
    rg(`CPT_A_FLAG, rd);
    chk("event flag cleared", 16'h0000, rd);
    hits = 0;
    for (int s = 0; s < 5; s++) begin
      if (s == 1) continue;
      wr(`CPT_A_EXT, 8'(s));
      wr(`CPT_A_FLAG, 8'h00);
      wr(`CPT_A_CTRL, (s == 0) ? 8'h00 : 8'h10);
      wr(`CPT_A_EXT, 8'(s + 16));
      repeat (1000) @(negedge mclk);
      rg(`CPT_A_FLAG, rd);
      chk("flag by source", (s == 0) ? 16'h0010 : 16'h0000, rd);
    end
    chk("lines idle", 16'h0000, 16'(hits));
    chk("open-drain data", 16'h0000, {14'h0000, irq_a, irq_b});
    wr(`CPT_A_EXT, 8'h01);
    wr(`CPT_A_TPLO, 8'h34);
    wr(`CPT_A_TPHI, 8'h12);
    wr(`CPT_A_CTRL, 8'h00);
    wr(`CPT_A_EXT, 8'h11);
    rdcnt(v1);
    chk("live count", 16'h0001, 16'(v1 == 16'h1234 || v1 == 16'h1233));
    // Pause, stop and the supply-mode filter must each hold the count without loss.
    foreach (pz[j]) begin
      wr(`CPT_A_CTRL, pz[j]);
      rdcnt(v1);
      repeat (1500) @(negedge mclk);
      rdcnt(v2);
      chk("paused count", v1, v2);
      wr(`CPT_A_CTRL, 8'h00);
      repeat (1100) @(negedge mclk);
      rdcnt(v2);
      chk("resumed count", 16'h0001, 16'((v1 - v2) inside {[1:3]}));
    end
    wr(`CPT_A_EXT, 8'h01);
    rdcnt(v1);
    chk("preset when stopped", 16'h1234, v1);
    wr(`CPT_A_EXT, 8'h11);
    rdcnt(v1);
    chk("restart count", 16'h0001, 16'(v1 == 16'h1234 || v1 == 16'h1233));
    @(negedge mclk) rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    rg(`CPT_A_WEEK, rd);
    chk("weekday after reset", 16'h0001, rd);
    summarize();
  end
endmodule // cpt_top_bench
